// ### uart_line_modem_status_test.sv
`timescale 1ns/10ps
module uart_line_modem_status_test;
    reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    reg s_axi_rready, rx_char_valid, rx_char_frame_err, rx_char_parity_err;
    reg rx_char_break, rx_start_bit, tx_empty_in, tx_hold_empty_in, tx_shift_in;
    reg line_break;
    reg [11:0] s_axi_awaddr, s_axi_araddr;
    reg [31:0] s_axi_wdata;
    reg [3:0] s_axi_wstrb, lines, pins;
    reg [7:0] rx_char_data, q, m;
    reg [1:0] rsp;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire rx_pin_in, tx_pin_out, rx_shift_feed, tx_write_valid, fifo_enable;
    wire loopback_enable, carrier_detect_in, bell_signal_in, set_ready_in;
    wire send_clear_in, terminal_ready_out, request_send_out;
    wire [7:0] tx_write_data, line_control;
    wire [15:0] baud_divisor;
    wire [3:0] pb_pin_in, pb_pin_out, pb_pin_oe, pb_far;
    integer seed = 32'hd43f;
    integer mismatches, n_compared, i, k;
    assign pb_pin_in = (pb_pin_oe & pb_pin_out) | (~pb_pin_oe & pb_far);
    ulms_top u_dut (.*);
    ulms_modem u_mdm (.*);
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        {tx_shift_in, tx_empty_in, tx_hold_empty_in} <= $random(seed);
    end
    task report_and_stop;
        begin
            if (mismatches == 0 && n_compared > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input [7:0] g, input [7:0] e);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("MISMATCH %0t %h %h", $time, g, e);
            end
        end
    endtask
    task tmo;
        if (i >= 64) begin
            mismatches = mismatches + 1;
            report_and_stop;
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge aclk);
    endtask
    task wr(input [11:0] a, input [7:0] d);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= {24'h0, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            i = 0;
            do begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
                i = i + 1;
            end while (!s_axi_bvalid && i < 64);
            rsp = s_axi_bresp;
            tmo;
        end
    endtask
    task rd(input [11:0] a);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            i = 0;
            do begin
                @(posedge aclk);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
                i = i + 1;
            end while (!s_axi_rvalid && i < 64);
            q = s_axi_rdata[7:0];
            rsp = s_axi_rresp;
            tmo;
        end
    endtask
    task rx(input [7:0] d, input [2:0] e);
        begin
            rx_char_data <= d;
            {rx_char_break, rx_char_frame_err, rx_char_parity_err} <= e;
            rx_char_valid <= 1'b1;
            @(posedge aclk);
            rx_char_valid <= 1'b0;
            @(posedge aclk);
        end
    endtask
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h05;
        {rx_char_valid, rx_char_frame_err, rx_char_parity_err, rx_char_break} = 4'h0;
        {rx_start_bit, line_break} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_char_data} = 64'h0;
        {lines, pins} = 8'h00;
        s_axi_wstrb = 4'hF;
        mismatches = 0;
        n_compared = 0;
        aresetn = 1'b0;
        tick(5);
        aresetn <= 1'b1;
        tick(1);
        rd(12'h004);
        chk(q, 8'h00);
        m = $random(seed);
        wr(12'h15C, m);
        rd(12'h15C);
        chk(q, m);
        rd(12'h3F0);
        chk(q, 8'h00);
        chk({6'h00, rsp}, 8'h02);
        wr(12'h3F0, m);
        chk({6'h00, rsp}, 8'h02);
        wr(12'h14C, 8'h80);
        wr(12'h140, m);
        wr(12'h144, ~m);
        rd(12'h144);
        chk(q, ~m);
        chk(baud_divisor[7:0], m);
        wr(12'h14C, 8'h03);
        wr(12'h140, 8'h55);
        rd(12'h144);
        chk(q, 8'h00);
        chk(baud_divisor[15:8], ~m);
        chk(line_control, 8'h03);
        chk(tx_write_data, 8'h55);
        lines <= {m[3], 1'b1, m[1:0]};
        tick(3);
        rd(12'h158);
        chk({4'h0, q[7:4]}, {4'h0, lines});
        rd(12'h158);
        chk(q & 8'h0F, 8'h00);
        lines <= lines ^ 4'hB;
        tick(3);
        rd(12'h158);
        chk(q & 8'h0F, 8'h0B);
        lines <= lines & 4'hB;
        tick(3);
        rd(12'h158);
        chk(q & 8'h0F, 8'h04);
        rd(12'h158);
        chk(q & 8'h0F, 8'h00);
        wr(12'h150, {4'h1, m[7:4]});
        rd(12'h158);
        chk({4'h0, q[7:4]}, {4'h0, m[7], m[6], m[4], m[5]});
        chk({6'h00, terminal_ready_out, request_send_out}, {6'h00, m[4], m[5]});
        wr(12'h150, 8'h01);
        wr(12'h288, 8'h0F);
        wr(12'h004, 8'h01);
        pins <= m[3:0];
        tick(3);
        rd(12'h158);
        chk({5'h00, q[7:5]}, {5'h00, m[0], m[1], m[2]});
        chk({3'h0, pb_pin_in[3], pb_pin_oe}, 8'h18);
        wr(12'h004, 8'h00);
        tick(2);
        chk({4'h0, pb_pin_oe}, 8'h0F);
        rx(8'h5A, 3'b011);
        rd(12'h154);
        chk(q & 8'h1F, 8'h0D);
        rd(12'h154);
        chk(q & 8'h1F, 8'h01);
        rx(m, 3'b000);
        rd(12'h154);
        chk(q & 8'h03, 8'h03);
        rd(12'h140);
        chk(q, m);
        rd(12'h154);
        chk(q & 8'h03, 8'h00);
        wr(12'h148, 8'h01);
        rx(8'h11, 3'b001);
        rx(8'h22, 3'b000);
        rd(12'h154);
        chk(q & 8'h05, 8'h05);
        rd(12'h140);
        chk(q, 8'h11);
        rd(12'h154);
        chk(q & 8'h05, 8'h01);
        wr(12'h148, 8'h00);
        rd(12'h154);
        chk({7'h00, q[0] | fifo_enable}, 8'h00);
        wr(12'h148, 8'h01);
        for (k = 0; k < 17; k = k + 1) rx(k[7:0], 3'b000);
        rd(12'h154);
        chk(q & 8'h03, 8'h03);
        for (k = 0; k < 16; k = k + 1) begin
            rd(12'h140);
            chk(q, k[7:0]);
        end
        rd(12'h154);
        chk(q & 8'h01, 8'h00);
        line_break <= 1'b1;
        rx(8'hAA, 3'b100);
        rx(8'h33, 3'b000);
        rd(12'h154);
        chk(q & 8'h11, 8'h11);
        line_break <= 1'b0;
        tick(3);
        rx_start_bit <= 1'b1;
        tick(1);
        rx_start_bit <= 1'b0;
        rx(8'h44, 3'b000);
        rd(12'h140);
        chk(q, 8'h00);
        rd(12'h140);
        chk(q, 8'h44);
        report_and_stop;
    end
endmodule

// ### ulms_defines.vh
`ifndef ULMS_DEFINES_VH
`define ULMS_DEFINES_VH
`define ULMS_OFF_CHIP_CFG 12'h004
`define ULMS_OFF_DIV_LOW 12'h140
`define ULMS_OFF_DIV_HIGH 12'h144
`define ULMS_OFF_FIFO_CTRL 12'h148
`define ULMS_OFF_LINE_CTRL 12'h14C
`define ULMS_OFF_MODEM_CTRL 12'h150
`define ULMS_OFF_LINE_STAT 12'h154
`define ULMS_OFF_MODEM_STAT 12'h158
`define ULMS_OFF_SCRATCH 12'h15C
`define ULMS_OFF_PB_OUT 12'h280
`define ULMS_OFF_PB_IN 12'h284
`define ULMS_OFF_PORT_B_DIRECTION 12'h288
`define ULMS_CFG_PB_ROUTE 0
`define ULMS_FCR_ENABLE 0
`define ULMS_FCR_RX_RESET 1
`define ULMS_LCR_DIVISOR_LATCH_ACCESS_BIT 7
`define ULMS_MCR_DTR 0
`define ULMS_MCR_RTS 1
`define ULMS_MCR_SPARE_OUTPUT_ONE 2
`define ULMS_MCR_SPARE_OUTPUT_TWO 3
`define ULMS_MCR_LOOP 4
`define ULMS_ST_PE 8
`define ULMS_ST_FE 9
`define ULMS_ST_BI 10
`define ULMS_PB_DTR_PIN 3
`define ULMS_PB_ROUTE_OE 4'h8
`define ULMS_RESP_OKAY 2'h0
`define ULMS_RESP_SLVERR 2'h2
`define ULMS_ZERO8 8'h00
`define ULMS_ZERO4 4'h0
`define ULMS_RX_DEPTH 16
`define ULMS_RX_AW 4
`endif

// ### ulms_fifo.v
`timescale 1ns/10ps
module ulms_fifo #(
    parameter W = 11,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire aclk,
    input wire aresetn,
    input wire flush,
    input wire push,
    input wire [W-1:0] din,
    input wire pop,
    output wire [W-1:0] dout,
    output wire empty,
    output wire full
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] rd_ptr;
    reg [AW-1:0] wr_ptr;
    reg [AW:0] count;
    wire do_push;
    wire do_pop;
    assign empty = (count == {(AW+1){1'b0}});
    assign full = (count == DEPTH[AW:0]);
    assign dout = mem[rd_ptr];
    assign do_push = push && !full;
    assign do_pop = pop && !empty;
    always @(posedge aclk) begin
        if (do_push) begin
            mem[wr_ptr] <= din;
        end
    end
    always @(posedge aclk) begin
        if (!aresetn || flush) begin
            rd_ptr <= {AW{1'b0}};
            wr_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (do_push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                count <= count + 1'b1;
            end else if (do_pop && !do_push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// ### ulms_modem.sv
`timescale 1ns/10ps
module ulms_modem (
    input wire aclk,
    input wire [3:0] lines,
    input wire [3:0] pins,
    input wire line_break,
    output reg carrier_detect_in,
    output reg bell_signal_in,
    output reg set_ready_in,
    output reg send_clear_in,
    output reg rx_pin_in,
    output reg [3:0] pb_far
);
    // The serial line idles marking; a break holds it at space.
    always @(posedge aclk) begin
        {carrier_detect_in, bell_signal_in, set_ready_in, send_clear_in} <= lines;
        rx_pin_in <= !line_break;
        pb_far <= pins;
    end
endmodule

// ### ulms_props.sv
`timescale 1ns/10ps
module ulms_props (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire tx_shift_in,
    input wire rx_pin_in,
    input wire tx_pin_out,
    input wire rx_shift_feed,
    input wire loopback_enable
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer moved");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
        s_axi_rdata == 32'h0) else $error("refused read data");
    a_loop_tx_high: assert property (loopback_enable [*3] |-> tx_pin_out)
        else $error("line not marking in loopback");
    a_tx_follow: assert property (!loopback_enable [*3] |->
        tx_pin_out == $past(tx_shift_in)) else $error("line not following shifter");
    a_rx_loop: assert property (loopback_enable [*3] |->
        rx_shift_feed == $past(tx_shift_in)) else $error("receiver not looped");
    a_rx_direct: assert property (!loopback_enable [*3] |->
        rx_shift_feed == $past(rx_pin_in)) else $error("receiver not on pin");
endmodule
bind ulms_top ulms_props u_props (.*);

// ### ulms_top.v
`timescale 1ns/10ps
`include "ulms_defines.vh"
// Contract
// RULE_01 - Break in FIFO mode: one zero char, then lock
// RULE_02 - Framing error sticky, cleared by status read
// RULE_03 - Parity error sticky, cleared by status read
// RULE_04 - FIFO mode: per-char status shown at head
// RULE_05 - Holding buffer overwritten unread sets overrun
// RULE_06 - Full FIFO plus new char sets overrun
// RULE_07 - Data ready follows buffer or FIFO fill
// RULE_08 - FIFO enable change clears data ready
// RULE_09 - Loopback off: status shows external modem inputs
// RULE_10 - Loopback on: status mirrors modem control outputs
// RULE_11 - Set-ready change flag, cleared on status read
// RULE_12 - Clear-to-send change flag, cleared on status read
// RULE_13 - Ring falling edge sets bell end flag
// RULE_14 - Scratch byte is plain read/write storage
// RULE_15 - Divisor bytes reachable only with access bit
// RULE_16 - Routing bit makes port B modem pins
// RULE_17 - Routed port B ignores stored direction
// RULE_18 - Routing bit is zero after reset
// RULE_19 - Loopback forces line high, links shift registers
// RULE_20 - Carrier change flag, cleared on status read
// RULE_21 - Read clears deltas; concurrent change is kept
module ulms_top #(
    parameter ADDR_W = 12,
    parameter RX_DEPTH = `ULMS_RX_DEPTH,
    parameter RX_AW = `ULMS_RX_AW
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire rx_char_valid,
    input wire [7:0] rx_char_data,
    input wire rx_char_frame_err,
    input wire rx_char_parity_err,
    input wire rx_char_break,
    input wire rx_start_bit,
    input wire tx_empty_in,
    input wire tx_hold_empty_in,
    input wire tx_shift_in,
    input wire rx_pin_in,
    output reg tx_pin_out,
    output reg rx_shift_feed,
    output reg tx_write_valid,
    output reg [7:0] tx_write_data,
    output reg [15:0] baud_divisor,
    output reg [7:0] line_control,
    output reg fifo_enable,
    output reg loopback_enable,
    input wire carrier_detect_in,
    input wire bell_signal_in,
    input wire set_ready_in,
    input wire send_clear_in,
    output reg terminal_ready_out,
    output reg request_send_out,
    input wire [3:0] pb_pin_in,
    output reg [3:0] pb_pin_out,
    output reg [3:0] pb_pin_oe
);
    reg [7:0] baud_divisor_low;
    reg [7:0] baud_divisor_high;
    reg [7:0] scratch_byte;
    reg [4:0] modem_control;
    reg [7:0] line_ctrl;
    reg fifo_on;
    reg chip_cfg_route;
    reg [3:0] port_b_direction;
    reg [3:0] port_b_out;
    reg [ADDR_W-1:0] aw_addr;
    reg aw_full;
    reg [7:0] w_byte;
    reg w_lane0;
    reg w_full;
    reg [7:0] rx_hold;
    reg rx_hold_full;
    reg framing_error_flag;
    reg parity_error_flag;
    reg break_flag;
    reg overrun_flag;
    reg break_lock;
    reg mark_seen;
    reg [RX_AW:0] err_count;
    reg [3:0] mdm_prev;
    reg carrier_change_flag;
    reg bell_end_flag;
    reg set_ready_change_flag;
    reg send_clear_change_flag;
    reg [7:0] rd_byte;
    reg rd_hit;
    wire divisor_latch_access_bit;
    wire loop_on;
    wire [3:0] mdm_ext;
    wire [3:0] mdm_loop;
    wire [3:0] mdm_now;
    wire line_in;
    wire [10:0] head;
    wire fifo_empty;
    wire fifo_full;
    wire accept;
    wire char_err;
    wire head_err;
    wire wr_fire;
    wire rd_fire;
    wire wr_rbr;
    wire rd_rbr;
    wire rd_lsr;
    wire rd_msr;
    wire wr_fcr;
    wire fifo_flush;
    wire fifo_push;
    wire fifo_pop;
    wire [7:0] lsr_value;
    wire rx_ready;
    assign divisor_latch_access_bit = line_ctrl[`ULMS_LCR_DIVISOR_LATCH_ACCESS_BIT];
    assign loop_on = modem_control[`ULMS_MCR_LOOP];
    assign mdm_ext[3] = chip_cfg_route ? pb_pin_in[0] : carrier_detect_in; // RULE_16
    assign mdm_ext[2] = chip_cfg_route ? pb_pin_in[1] : bell_signal_in; // RULE_16
    assign mdm_ext[1] = chip_cfg_route ? pb_pin_in[2] : set_ready_in; // RULE_16
    assign mdm_ext[0] = send_clear_in;
    assign mdm_loop = {modem_control[`ULMS_MCR_SPARE_OUTPUT_TWO], modem_control[`ULMS_MCR_SPARE_OUTPUT_ONE],
                       modem_control[`ULMS_MCR_DTR], modem_control[`ULMS_MCR_RTS]};
    assign mdm_now = loop_on ? mdm_loop : mdm_ext; // RULE_09 RULE_10
    assign line_in = loop_on ? tx_shift_in : rx_pin_in; // RULE_19
    assign wr_fire = aw_full && w_full && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign wr_rbr = wr_fire && w_lane0 && !divisor_latch_access_bit && (aw_addr == `ULMS_OFF_DIV_LOW);
    assign rd_rbr = rd_fire && !divisor_latch_access_bit && (s_axi_araddr == `ULMS_OFF_DIV_LOW);
    assign rd_lsr = rd_fire && (s_axi_araddr == `ULMS_OFF_LINE_STAT);
    assign rd_msr = rd_fire && (s_axi_araddr == `ULMS_OFF_MODEM_STAT);
    assign wr_fcr = wr_fire && w_lane0 && (aw_addr == `ULMS_OFF_FIFO_CTRL);
    assign fifo_flush = wr_fcr && ((w_byte[`ULMS_FCR_ENABLE] != fifo_on) ||
                                   w_byte[`ULMS_FCR_RX_RESET]); // RULE_08
    assign accept = rx_char_valid && !break_lock; // RULE_01
    assign char_err = rx_char_frame_err || rx_char_parity_err || rx_char_break;
    assign fifo_push = accept && fifo_on && !fifo_flush; // RULE_06
    assign fifo_pop = rd_rbr && fifo_on;
    assign head_err = !fifo_empty && (head[`ULMS_ST_PE] || head[`ULMS_ST_FE] ||
                                      head[`ULMS_ST_BI]);
    assign rx_ready = fifo_on ? !fifo_empty : rx_hold_full; // RULE_07
    assign lsr_value = {fifo_on && (err_count != {(RX_AW+1){1'b0}}), tx_empty_in,
                        tx_hold_empty_in,
                        fifo_on ? (head[`ULMS_ST_BI] && !fifo_empty) : break_flag,
                        fifo_on ? (head[`ULMS_ST_FE] && !fifo_empty) : framing_error_flag,
                        fifo_on ? (head[`ULMS_ST_PE] && !fifo_empty) : parity_error_flag,
                        overrun_flag, rx_ready}; // RULE_04

    ulms_fifo #(
        .W(11),
        .DEPTH(RX_DEPTH),
        .AW(RX_AW)
    ) u_rx_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .flush(fifo_flush),
        .push(fifo_push),
        .din({rx_char_break, rx_char_frame_err, rx_char_parity_err,
              rx_char_break ? `ULMS_ZERO8 : rx_char_data}), // RULE_01 RULE_04
        .pop(fifo_pop),
        .dout(head),
        .empty(fifo_empty),
        .full(fifo_full)
    );

    always @* begin
        rd_hit = 1'b1;
        rd_byte = `ULMS_ZERO8;
        case (s_axi_araddr)
            `ULMS_OFF_CHIP_CFG: rd_byte = {7'h00, chip_cfg_route};
            `ULMS_OFF_DIV_LOW: rd_byte = divisor_latch_access_bit ? baud_divisor_low :
                                 (fifo_on ? head[7:0] : rx_hold); // RULE_15
            `ULMS_OFF_DIV_HIGH: rd_byte = divisor_latch_access_bit ? baud_divisor_high : `ULMS_ZERO8; // RULE_15
            `ULMS_OFF_FIFO_CTRL: rd_byte = {7'h00, fifo_on};
            `ULMS_OFF_LINE_CTRL: rd_byte = line_ctrl;
            `ULMS_OFF_MODEM_CTRL: rd_byte = {3'h0, modem_control};
            `ULMS_OFF_LINE_STAT: rd_byte = lsr_value;
            `ULMS_OFF_MODEM_STAT: rd_byte = {mdm_prev, carrier_change_flag, bell_end_flag,
                                             set_ready_change_flag, send_clear_change_flag};
            `ULMS_OFF_SCRATCH: rd_byte = scratch_byte; // RULE_14
            `ULMS_OFF_PB_OUT: rd_byte = {4'h0, port_b_out};
            `ULMS_OFF_PB_IN: rd_byte = {4'h0, pb_pin_in};
            `ULMS_OFF_PORT_B_DIRECTION: rd_byte = {4'h0, port_b_direction};
            default: rd_hit = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ULMS_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `ULMS_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            aw_addr <= {ADDR_W{1'b0}};
            aw_full <= 1'b0;
            w_byte <= `ULMS_ZERO8;
            w_lane0 <= 1'b0;
            w_full <= 1'b0;
        end else begin
            if (!aw_full && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (!w_full && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                aw_full <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
                w_full <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr)
                    `ULMS_OFF_CHIP_CFG, `ULMS_OFF_DIV_LOW, `ULMS_OFF_DIV_HIGH,
                    `ULMS_OFF_FIFO_CTRL, `ULMS_OFF_LINE_CTRL, `ULMS_OFF_MODEM_CTRL,
                    `ULMS_OFF_LINE_STAT, `ULMS_OFF_MODEM_STAT, `ULMS_OFF_SCRATCH,
                    `ULMS_OFF_PB_OUT, `ULMS_OFF_PB_IN, `ULMS_OFF_PORT_B_DIRECTION: begin
                        s_axi_bresp <= `ULMS_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `ULMS_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (!s_axi_rvalid && !rd_fire) begin
                s_axi_arready <= 1'b1;
            end
            if (rd_fire) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_hit ? `ULMS_RESP_OKAY : `ULMS_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            baud_divisor_low <= `ULMS_ZERO8;
            baud_divisor_high <= `ULMS_ZERO8;
            scratch_byte <= `ULMS_ZERO8;
            modem_control <= 5'h00;
            line_ctrl <= `ULMS_ZERO8;
            fifo_on <= 1'b0;
            chip_cfg_route <= 1'b0; // RULE_18
            port_b_direction <= `ULMS_ZERO4;
            port_b_out <= `ULMS_ZERO4;
            tx_write_valid <= 1'b0;
            tx_write_data <= `ULMS_ZERO8;
        end else begin
            tx_write_valid <= wr_rbr;
            if (wr_rbr) begin
                tx_write_data <= w_byte;
            end
            if (wr_fire && w_lane0) begin
                case (aw_addr)
                    `ULMS_OFF_CHIP_CFG: chip_cfg_route <= w_byte[`ULMS_CFG_PB_ROUTE];
                    `ULMS_OFF_DIV_LOW: if (divisor_latch_access_bit) begin
                        baud_divisor_low <= w_byte; // RULE_15
                    end
                    `ULMS_OFF_DIV_HIGH: if (divisor_latch_access_bit) begin
                        baud_divisor_high <= w_byte; // RULE_15
                    end
                    `ULMS_OFF_FIFO_CTRL: fifo_on <= w_byte[`ULMS_FCR_ENABLE];
                    `ULMS_OFF_LINE_CTRL: line_ctrl <= w_byte;
                    `ULMS_OFF_MODEM_CTRL: modem_control <= w_byte[4:0];
                    `ULMS_OFF_SCRATCH: scratch_byte <= w_byte; // RULE_14
                    `ULMS_OFF_PB_OUT: port_b_out <= w_byte[3:0];
                    `ULMS_OFF_PORT_B_DIRECTION: port_b_direction <= w_byte[3:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_hold <= `ULMS_ZERO8;
            rx_hold_full <= 1'b0;
            framing_error_flag <= 1'b0;
            parity_error_flag <= 1'b0;
            break_flag <= 1'b0;
            overrun_flag <= 1'b0;
            break_lock <= 1'b0;
            mark_seen <= 1'b0;
            err_count <= {(RX_AW+1){1'b0}};
        end else begin
            if (rd_lsr) begin
                framing_error_flag <= 1'b0; // RULE_02
                parity_error_flag <= 1'b0; // RULE_03
                break_flag <= 1'b0;
                overrun_flag <= 1'b0; // RULE_05
            end
            if (rd_rbr && !fifo_on) begin
                rx_hold_full <= 1'b0; // RULE_07
            end
            if (fifo_flush) begin
                rx_hold_full <= 1'b0; // RULE_08
                err_count <= {(RX_AW+1){1'b0}};
            end else if ((fifo_push && !fifo_full && char_err) && !(fifo_pop && head_err)) begin
                err_count <= err_count + 1'b1;
            end else if (!(fifo_push && !fifo_full && char_err) && (fifo_pop && head_err)) begin
                err_count <= err_count - 1'b1;
            end
            if (break_lock) begin
                if (line_in) begin
                    mark_seen <= 1'b1;
                end
                if (mark_seen && rx_start_bit) begin
                    break_lock <= 1'b0; // RULE_01
                    mark_seen <= 1'b0;
                end
            end
            if (accept && fifo_on) begin
                if (fifo_full) begin
                    overrun_flag <= 1'b1; // RULE_06
                end else if (rx_char_break) begin
                    break_lock <= 1'b1; // RULE_01
                    mark_seen <= 1'b0;
                end
            end else if (accept) begin
                if (rx_hold_full && !rd_rbr) begin
                    overrun_flag <= 1'b1; // RULE_05
                end
                rx_hold <= rx_char_data;
                rx_hold_full <= !fifo_flush; // RULE_07
                if (rx_char_frame_err) begin
                    framing_error_flag <= 1'b1; // RULE_02
                end
                if (rx_char_parity_err) begin
                    parity_error_flag <= 1'b1; // RULE_03
                end
                if (rx_char_break) begin
                    break_flag <= 1'b1;
                end
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            mdm_prev <= `ULMS_ZERO4;
            carrier_change_flag <= 1'b0;
            bell_end_flag <= 1'b0;
            set_ready_change_flag <= 1'b0;
            send_clear_change_flag <= 1'b0;
        end else begin
            mdm_prev <= mdm_now;
            if (rd_msr) begin
                carrier_change_flag <= 1'b0; // RULE_21
                bell_end_flag <= 1'b0;
                set_ready_change_flag <= 1'b0;
                send_clear_change_flag <= 1'b0;
            end
            if (mdm_now[3] != mdm_prev[3]) begin
                carrier_change_flag <= 1'b1; // RULE_20 RULE_21
            end
            if (mdm_prev[2] && !mdm_now[2]) begin
                bell_end_flag <= 1'b1; // RULE_13
            end
            if (mdm_now[1] != mdm_prev[1]) begin
                set_ready_change_flag <= 1'b1; // RULE_11
            end
            if (mdm_now[0] != mdm_prev[0]) begin
                send_clear_change_flag <= 1'b1; // RULE_12
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_pin_out <= 1'b1;
            rx_shift_feed <= 1'b1;
            baud_divisor <= 16'h0000;
            line_control <= `ULMS_ZERO8;
            fifo_enable <= 1'b0;
            loopback_enable <= 1'b0;
            terminal_ready_out <= 1'b0;
            request_send_out <= 1'b0;
            pb_pin_out <= `ULMS_ZERO4;
            pb_pin_oe <= `ULMS_ZERO4;
        end else begin
            tx_pin_out <= loop_on ? 1'b1 : tx_shift_in; // RULE_19
            rx_shift_feed <= line_in; // RULE_19
            baud_divisor <= {baud_divisor_high, baud_divisor_low};
            line_control <= line_ctrl;
            fifo_enable <= fifo_on;
            loopback_enable <= loop_on;
            terminal_ready_out <= modem_control[`ULMS_MCR_DTR];
            request_send_out <= modem_control[`ULMS_MCR_RTS];
            if (chip_cfg_route) begin
                pb_pin_oe <= `ULMS_PB_ROUTE_OE; // RULE_17
                pb_pin_out <= {modem_control[`ULMS_MCR_DTR], 3'h0}; // RULE_16
            end else begin
                pb_pin_oe <= port_b_direction; // RULE_17
                pb_pin_out <= port_b_out;
            end
        end
    end
endmodule
